//--- group_walk_pkg.sv
// Constants and register map of the thread-group walk dispatcher.
package group_walk_pkg;
	// Register byte offsets on the Avalon-MM slave.
	localparam logic [6:0] ctrl_off = 7'h00;
	localparam logic [6:0] status_off = 7'h04;
	localparam logic [6:0] x_init_off = 7'h08;
	localparam logic [6:0] x_max_off = 7'h0c;
	localparam logic [6:0] y_init_off = 7'h10;
	localparam logic [6:0] y_max_off = 7'h14;
	localparam logic [6:0] z_init_off = 7'h18;
	localparam logic [6:0] z_max_off = 7'h1c;
	localparam logic [6:0] thr_max_off = 7'h20;
	localparam logic [6:0] right_mask_off = 7'h24;
	localparam logic [6:0] bottom_mask_off = 7'h28;
	localparam logic [6:0] scratch_off = 7'h2c;
	localparam logic [6:0] bind_off = 7'h30;
	localparam logic [6:0] sampler_off = 7'h34;
	localparam logic [6:0] group_cfg_off = 7'h38;
	localparam logic [6:0] pay_base_off = 7'h3c;
	localparam logic [6:0] pay_len_off = 7'h40;
	localparam logic [6:0] disp_count_off = 7'h44;
	localparam int num_regs = 18;
	// Control and status fields.
	localparam int ctrl_start_bit = 0;
	localparam int ctrl_simd_lsb = 1;
	localparam logic [1:0] simd8 = 2'h0;
	localparam logic [1:0] simd16 = 2'h1;
	localparam logic [1:0] simd32 = 2'h2;
	localparam int st_busy_bit = 0;
	localparam int st_done_bit = 1;
	localparam int st_err_bit = 2;
	// Thread counter maxima fields, 6 bits each.
	localparam int thr_w_lsb = 0;
	localparam int thr_h_lsb = 8;
	localparam int thr_d_lsb = 16;
	localparam logic [17:0] simd32_limit = 18'h00020;
	localparam logic [17:0] simd16_limit = 18'h00040;
	// Header field positions.
	localparam int scratch_ptr_lsb = 10;
	localparam int compute_flag_bit = 9;
	localparam int align32_lsb = 5;
	localparam int barrier_en_bit = 29;
	localparam int slm_en_bit = 28;
	localparam int index_lsb = 24;
	localparam logic [3:0] stack_size_max = 4'hb;
	localparam logic [3:0] scratch_size_max = 4'hb;
	// Payload length field: per-dispatch length, cross-thread length, memory control.
	localparam int pay_len_lsb = 0;
	localparam int cross_len_lsb = 8;
	localparam int mem_ctl_lsb = 16;
	localparam int mem_ctl_width = 7;
	localparam int grf_bytes_log2 = 5;
	localparam int slot_count = 512;
endpackage : group_walk_pkg

//--- group_walk_dispatch.sv
// Thread-group walker that turns one walk command into a stream of thread dispatches.
// Operation
// R01: 32-bit X/Y/Z group counters, initial and maximum.
// R02: Each dispatch carries current X, Y, Z group IDs.
// R03: Three 6-bit thread counters, 32 or 64 dispatches.
// R04: One dispatch per thread counter increment.
// R05: All thread counters maxed ends group, next group.
// R06: X at maximum wraps to zero, Y increments.
// R07: Y wraps with X, Z increments; last group ends.
// R08: Issuer programs thread count and SIMD width.
// R09: Only thread counts sequence each group's dispatches.
// R10: Group IDs Z, Y, X in dwords 7, 6, 1.
// R11: Dword 5 holds scratch pointer, compute flag, slot.
// R12: Unique 9-bit slot per live thread, freed later.
// R13: Dword 4 binding table pointer, bit 4 zero.
// R14: Dword 4 low bits give stack size 0-11.
// R15: Dword 3 sampler pointer and scratch size exponent.
// R16: Dword 2 barrier enable, memory enable, barrier index.
// R17: Dword 0 bits 27:24 shared memory block index.
// R18: Dword 0 low half is return buffer handle.
// R19: Constants start at register 1, thread IDs follow.
// R20: Issuer always supplies constant or indirect payload.
// R21: Issuer uses only legal payload combinations.
// R22: Payload fetched at dispatch with dynamic-state memory control.
// R23: Every group gets identical per-dispatch payload sequence.
// R24: Issuer keeps group within one subslice's thread limit.
// R25: Command carries 32-bit right and bottom masks.
// R26: Right, bottom or ANDed mask chosen by counters.
//
// The Avalon-MM interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module group_walk_dispatch (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic resetn,
	// Avalon-MM register slave.
	input wire logic [6:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Dispatch stream to the thread spawner.
	output logic disp_valid,
	input wire logic disp_ready,
	output logic [7:0][31:0] disp_header,
	output logic [31:0] disp_exec_mask,
	output logic [31:0] disp_payload_addr,
	output logic [7:0] disp_payload_len,
	output logic [6:0] disp_mem_ctl,
	// Slot release from the thread dispatcher.
	input wire logic slot_release,
	input wire logic [8:0] slot_release_id
);
	typedef enum logic [1:0] {st_idle, st_run} walk_state_t;

	typedef struct packed {
		walk_state_t fsm;
		logic [group_walk_pkg::num_regs-1:0][31:0] regs;
		logic [31:0] gx;
		logic [31:0] gy;
		logic [31:0] gz;
		logic [5:0] tw;
		logic [5:0] th;
		logic [5:0] td;
		logic [11:0] disp_idx;
		logic [3:0] group_idx;
		logic [group_walk_pkg::slot_count-1:0] slot_busy;
		logic [8:0] slot_ptr;
		logic busy;
		logic done;
		logic err;
		logic valid;
		logic [7:0][31:0] header;
		logic [31:0] mask;
		logic [31:0] paddr;
		logic [7:0] plen;
		logic [6:0] mem_ctl;
		logic waitreq;
		logic [31:0] rdata;
	} state_t;

	state_t s_q;
	state_t s_d;
	logic rst_meta_q;
	logic rst_sync_q;

	// Reset is released through two flops so every state flop leaves reset on one edge.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	logic [4:0] reg_idx;
	logic [31:0] x_max;
	logic [31:0] y_max;
	logic [31:0] z_max;
	logic [5:0] w_max;
	logic [5:0] h_max;
	logic [5:0] d_max;
	logic last_w;
	logic last_h;
	logic last_d;
	logic group_end;
	logic last_x;
	logic last_y;
	logic last_z;
	logic emit;
	logic [17:0] thr_total;
	logic [31:0] byte_mask;
	logic [31:0] wdata_merged;
	logic [31:0] cross_bytes;
	logic [31:0] step_bytes;
	logic [3:0] stack_sz;
	logic [3:0] scratch_sz;

	always_comb begin
		reg_idx = avs_address[6:2];
		x_max = s_q.regs[group_walk_pkg::x_max_off[6:2]];
		y_max = s_q.regs[group_walk_pkg::y_max_off[6:2]];
		z_max = s_q.regs[group_walk_pkg::z_max_off[6:2]];
		w_max = s_q.regs[group_walk_pkg::thr_max_off[6:2]][group_walk_pkg::thr_w_lsb +: 6];
		h_max = s_q.regs[group_walk_pkg::thr_max_off[6:2]][group_walk_pkg::thr_h_lsb +: 6];
		d_max = s_q.regs[group_walk_pkg::thr_max_off[6:2]][group_walk_pkg::thr_d_lsb +: 6];
		thr_total = 18'(w_max) * 18'(h_max) * 18'(d_max);
		last_w = (s_q.tw >= w_max);
		last_h = (s_q.th >= h_max);
		last_d = (s_q.td >= d_max);
		group_end = last_w && last_h && last_d; // [R05]
		last_x = (s_q.gx >= x_max);
		last_y = (s_q.gy >= y_max);
		last_z = (s_q.gz >= z_max);
		// A dispatch leaves only when the output slot is free and the next thread slot is idle.
		emit = (s_q.fsm == st_run) && (!s_q.valid || disp_ready)
			&& !s_q.slot_busy[s_q.slot_ptr]; // [R04] [R12]
		for (int b = 0; b < 4; b++) begin
			byte_mask[8*b +: 8] = {8{avs_byteenable[b]}};
		end
		wdata_merged = (s_q.regs[reg_idx] & ~byte_mask) | (avs_writedata & byte_mask);
		cross_bytes = 32'(s_q.regs[group_walk_pkg::pay_len_off[6:2]]
			[group_walk_pkg::cross_len_lsb +: 8]) << group_walk_pkg::grf_bytes_log2;
		step_bytes = 32'(s_q.regs[group_walk_pkg::pay_len_off[6:2]]
			[group_walk_pkg::pay_len_lsb +: 8]) << group_walk_pkg::grf_bytes_log2;
		stack_sz = s_q.regs[group_walk_pkg::bind_off[6:2]][3:0];
		scratch_sz = s_q.regs[group_walk_pkg::sampler_off[6:2]][3:0];
	end

	always_comb begin
		s_d = s_q;
		// Bus: one cycle of waitrequest, then the access completes with waitrequest low.
		if ((avs_read || avs_write) && s_q.waitreq) begin
			s_d.waitreq = 1'b0;
			s_d.rdata = (reg_idx < 5'(group_walk_pkg::num_regs)) ? s_q.regs[reg_idx] : 32'h0;
			if (reg_idx == group_walk_pkg::status_off[6:2]) begin
				s_d.rdata = {29'h0, s_q.err, s_q.done, s_q.busy};
			end
		end else if (!s_q.waitreq) begin
			s_d.waitreq = 1'b1;
		end
		// Configuration is only written while no walk is running.
		if (avs_write && !s_q.waitreq && s_q.fsm == st_idle
			&& reg_idx >= group_walk_pkg::x_init_off[6:2]
			&& reg_idx <= group_walk_pkg::pay_len_off[6:2]) begin
			s_d.regs[reg_idx] = wdata_merged;
		end
		// Start of a walk command.
		if (avs_write && !s_q.waitreq && s_q.fsm == st_idle
			&& reg_idx == group_walk_pkg::ctrl_off[6:2]
			&& avs_writedata[group_walk_pkg::ctrl_start_bit]) begin
			s_d.regs[group_walk_pkg::ctrl_off[6:2]] = avs_writedata;
			s_d.done = 1'b0;
			// The walker sees only the thread count; SIMD32 groups are capped lower. [R03] [R09]
			if (thr_total == 18'h0 || thr_total > group_walk_pkg::simd16_limit
				|| (avs_writedata[group_walk_pkg::ctrl_simd_lsb +: 2] == group_walk_pkg::simd32
				&& thr_total > group_walk_pkg::simd32_limit)) begin
				s_d.err = 1'b1;
			end else begin
				s_d.err = 1'b0;
				s_d.busy = 1'b1;
				s_d.fsm = st_run;
				s_d.gx = s_q.regs[group_walk_pkg::x_init_off[6:2]]; // [R01]
				s_d.gy = s_q.regs[group_walk_pkg::y_init_off[6:2]];
				s_d.gz = s_q.regs[group_walk_pkg::z_init_off[6:2]];
				s_d.tw = 6'h01;
				s_d.th = 6'h01;
				s_d.td = 6'h01;
				s_d.disp_idx = 12'h0;
			end
		end
		// Output register drains on acceptance.
		if (s_q.valid && disp_ready) begin
			s_d.valid = 1'b0;
		end
		// Completed threads give their slot back.
		if (slot_release) begin
			s_d.slot_busy[slot_release_id] = 1'b0; // [R12]
		end
		if (emit) begin
			s_d.valid = 1'b1;
			s_d.slot_busy[s_q.slot_ptr] = 1'b1; // [R12]
			s_d.slot_ptr = s_q.slot_ptr + 9'h1;
			s_d.regs[group_walk_pkg::disp_count_off[6:2]] =
				s_q.regs[group_walk_pkg::disp_count_off[6:2]] + 32'h1;
			s_d.header[0] = {4'h0, s_q.group_idx, 8'h0,
				s_q.regs[group_walk_pkg::group_cfg_off[6:2]][15:0]}; // [R17] [R18]
			s_d.header[1] = s_q.gx; // [R02] [R10]
			s_d.header[2] = {2'h0,
				s_q.regs[group_walk_pkg::group_cfg_off[6:2]][group_walk_pkg::barrier_en_bit],
				s_q.regs[group_walk_pkg::group_cfg_off[6:2]][group_walk_pkg::slm_en_bit],
				s_q.group_idx, 24'h0}; // [R16]
			s_d.header[3] = {s_q.regs[group_walk_pkg::sampler_off[6:2]][31:5], 1'b0,
				(scratch_sz > group_walk_pkg::scratch_size_max)
				? group_walk_pkg::scratch_size_max : scratch_sz}; // [R15]
			s_d.header[4] = {s_q.regs[group_walk_pkg::bind_off[6:2]][31:5], 1'b0,
				(stack_sz > group_walk_pkg::stack_size_max)
				? group_walk_pkg::stack_size_max : stack_sz}; // [R13] [R14]
			s_d.header[5] = {s_q.regs[group_walk_pkg::scratch_off[6:2]][31:10], 1'b1,
				s_q.slot_ptr}; // [R11]
			s_d.header[6] = s_q.gy; // [R10]
			s_d.header[7] = s_q.gz; // [R10]
			// Edge masks picked from the counters, ANDed at the corner. [R25] [R26]
			s_d.mask = {32{1'b1}};
			if (last_w) begin
				s_d.mask = s_d.mask & s_q.regs[group_walk_pkg::right_mask_off[6:2]];
			end
			if (last_h) begin
				s_d.mask = s_d.mask & s_q.regs[group_walk_pkg::bottom_mask_off[6:2]];
			end
			// Constants sit after the header; this dispatch's thread IDs follow them. [R19] [R22]
			s_d.paddr = s_q.regs[group_walk_pkg::pay_base_off[6:2]] + cross_bytes
				+ 32'(s_q.disp_idx) * step_bytes;
			s_d.plen = s_q.regs[group_walk_pkg::pay_len_off[6:2]][group_walk_pkg::pay_len_lsb +: 8];
			s_d.mem_ctl = s_q.regs[group_walk_pkg::pay_len_off[6:2]]
				[group_walk_pkg::mem_ctl_lsb +: group_walk_pkg::mem_ctl_width]; // [R22]
			// Thread counters: width first, then height, depth when both wrap. [R04] [R26]
			s_d.tw = last_w ? 6'h01 : s_q.tw + 6'h01;
			if (last_w) begin
				s_d.th = last_h ? 6'h01 : s_q.th + 6'h01;
				if (last_h) begin
					s_d.td = last_d ? 6'h01 : s_q.td + 6'h01;
				end
			end
			s_d.disp_idx = s_q.disp_idx + 12'h1;
			if (group_end) begin
				// Payload sequence restarts so every group reads the same data. [R23]
				s_d.disp_idx = 12'h0;
				s_d.group_idx = s_q.group_idx + 4'h1;
				// X wraps to zero rather than to its initial value. [R05] [R06] [R07]
				s_d.gx = last_x ? 32'h0 : s_q.gx + 32'h1;
				if (last_x) begin
					s_d.gy = last_y ? 32'h0 : s_q.gy + 32'h1;
					if (last_y) begin
						s_d.gz = s_q.gz + 32'h1;
					end
				end
				if (last_x && last_y && last_z) begin
					s_d.fsm = st_idle; // [R07]
					s_d.busy = 1'b0;
					s_d.done = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			s_q <= '0;
			s_q.fsm <= st_idle;
			s_q.waitreq <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign avs_readdata = s_q.rdata;
	assign avs_waitrequest = s_q.waitreq;
	assign disp_valid = s_q.valid;
	assign disp_header = s_q.header;
	assign disp_exec_mask = s_q.mask;
	assign disp_payload_addr = s_q.paddr;
	assign disp_payload_len = s_q.plen;
	assign disp_mem_ctl = s_q.mem_ctl;

	// The checks below watch outputs against the state that caused them.
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_sync_q);

	sequence emit_corner_s;
		emit && last_w && last_h;
	endsequence

	sequence emit_group_end_s;
		emit && group_end;
	endsequence

	// A stalled dispatch must not change under the spawner while it waits.
	hold_stable_a: assert property (disp_valid && !disp_ready // [R04]
		|=> disp_valid && $stable(disp_header))
		else $error("dispatch changed while stalled");
	group_id_a: assert property (emit |=> disp_header[1] == $past(s_q.gx) // [R02]
		&& disp_header[6] == $past(s_q.gy) && disp_header[7] == $past(s_q.gz))
		else $error("group id does not match counters");
	corner_mask_a: assert property (emit_corner_s // [R26]
		|=> disp_exec_mask == ($past(s_q.regs[9]) & $past(s_q.regs[10])))
		else $error("corner mask is not the AND of edge masks");
	x_wrap_a: assert property (emit_group_end_s ##0 (last_x && !last_y) // [R06]
		|=> s_q.gx == 32'h0 && s_q.gy == $past(s_q.gy) + 32'h1)
		else $error("x did not wrap to zero with y step");
	// The walk must stop after the last group, not start over from the initial values.
	walk_end_a: assert property (emit_group_end_s ##0 (last_x && last_y && last_z) // [R07]
		|=> s_q.fsm == st_idle && s_q.done && !s_q.busy ##1 $stable(s_q.slot_ptr))
		else $error("walk did not end after last group");
	slot_taken_a: assert property (emit |=> s_q.slot_busy[disp_header[5][8:0]]) // [R12]
		else $error("issued slot not marked busy");
	header_const_a: assert property (disp_valid |-> disp_header[5][9] // [R11] [R13] [R14] [R15]
		&& !disp_header[4][4] && disp_header[4][3:0] <= 4'hb && disp_header[3][3:0] <= 4'hb)
		else $error("fixed header bits wrong");
	payload_restart_a: assert property (emit_group_end_s |=> s_q.disp_idx == 12'h0) // [R23]
		else $error("payload index not restarted");

	sequence emit_inner_s;
		emit && !last_w;
	endsequence

	sequence emit_right_s;
		emit && last_w && !last_h;
	endsequence

	sequence emit_bottom_s;
		emit && !last_w && last_h;
	endsequence

	// Width steps fastest; a missed step would silently drop a dispatch.
	width_step_a: assert property (emit_inner_s // [R04]
		|=> s_q.tw == $past(s_q.tw) + 6'h01 && s_q.th == $past(s_q.th))
		else $error("width counter did not step");
	right_mask_a: assert property (emit_right_s // [R26]
		|=> disp_exec_mask == $past(s_q.regs[9]))
		else $error("right edge mask not used");
	bottom_mask_a: assert property (emit_bottom_s // [R26]
		|=> disp_exec_mask == $past(s_q.regs[10]))
		else $error("bottom edge mask not used");
	depth_step_a: assert property (emit_corner_s ##0 !last_d // [R26]
		|=> s_q.td == $past(s_q.td) + 6'h01)
		else $error("depth counter did not step at the corner");
	group_step_a: assert property (emit_group_end_s ##0 !last_x // [R05]
		|=> s_q.gx == $past(s_q.gx) + 32'h1 && s_q.gy == $past(s_q.gy))
		else $error("group counter did not advance");
	y_wrap_a: assert property (emit_group_end_s ##0 (last_x && last_y && !last_z) // [R07]
		|=> s_q.gy == 32'h0 && s_q.gz == $past(s_q.gz) + 32'h1)
		else $error("y did not wrap with z step");
	inner_group_a: assert property (emit && !group_end // [R09]
		|=> $stable(s_q.gx) && $stable(s_q.gy) && $stable(s_q.gz))
		else $error("group id moved inside a group");
	plen_a: assert property (emit |=> disp_payload_len == $past(s_q.regs[16][7:0])) // [R22]
		else $error("payload length not taken from the command");

	// A slot still held by a live thread must never be handed out twice.
	slot_wait_a: assert property (s_q.slot_busy[s_q.slot_ptr] |=> $stable(s_q.slot_ptr)) // [R12]
		else $error("busy slot was handed out again");
	slot_order_a: assert property (emit |=> disp_header[5][8:0] == $past(s_q.slot_ptr)) // [R12]
		else $error("slot field is not the issued slot");
	release_clear_a: assert property (slot_release // [R12]
		&& !(emit && s_q.slot_ptr == slot_release_id) |=> !s_q.slot_busy[$past(slot_release_id)])
		else $error("released slot still marked busy");
	start_err_a: assert property (s_q.err |-> !s_q.busy && s_q.fsm == st_idle) // [R03]
		else $error("walk started despite a bad thread count");
endmodule : group_walk_dispatch

//--- spawner_model.sv
// Thread spawner model that takes dispatches and hands their slots back later.
`timescale 1ns/100ps
module spawner_model (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic resetn,
	// Pacing from the bench.
	input wire logic hold,
	input wire logic slow,
	// Dispatch stream.
	input wire logic disp_valid,
	output logic disp_ready,
	input wire logic [8:0] slot_id,
	// Slot return.
	output logic slot_release,
	output logic [8:0] slot_release_id
);
	logic [8:0] live_q[$];
	logic [1:0] pace_q;
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			live_q.delete();
			pace_q <= 2'h0;
			disp_ready <= 1'b0;
			slot_release <= 1'b0;
			slot_release_id <= 9'h000;
		end else begin
			pace_q <= pace_q + 2'h1;
			disp_ready <= !hold && (!slow || pace_q == 2'h0);
			if (disp_valid && disp_ready) begin
				live_q.push_back(slot_id);
			end
			// Threads retire late and in order, so a slot stays busy for a while.
			if (live_q.size() > 1 || (live_q.size() > 0 && pace_q[0])) begin
				slot_release <= 1'b1;
				slot_release_id <= live_q.pop_front();
			end else begin
				// A stale id must never look valid between pulses.
				slot_release <= 1'b0;
				slot_release_id <= ~slot_release_id;
			end
		end
	end
endmodule : spawner_model

//--- group_walk_dispatch_bench.sv
// Self-checking bench for the thread-group walk dispatcher.
`timescale 1ns/100ps
module group_walk_dispatch_bench;
	logic clk_sys;
	logic resetn;
	logic [6:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic disp_valid;
	logic disp_ready;
	logic [7:0][31:0] disp_header;
	logic [31:0] disp_exec_mask;
	logic [31:0] disp_payload_addr;
	logic [7:0] disp_payload_len;
	logic [6:0] disp_mem_ctl;
	logic slot_release;
	logic [8:0] slot_release_id;
	logic hold;
	logic slow;
	int error_cnt;
	int checked;
	int n_disp;

	group_walk_dispatch dut_u (.clk_sys(clk_sys), .resetn(resetn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.disp_valid(disp_valid), .disp_ready(disp_ready), .disp_header(disp_header),
		.disp_exec_mask(disp_exec_mask), .disp_payload_addr(disp_payload_addr),
		.disp_payload_len(disp_payload_len), .disp_mem_ctl(disp_mem_ctl),
		.slot_release(slot_release), .slot_release_id(slot_release_id));

	spawner_model far_u (.clk_sys(clk_sys), .resetn(resetn), .hold(hold), .slow(slow),
		.disp_valid(disp_valid), .disp_ready(disp_ready), .slot_id(disp_header[5][8:0]),
		.slot_release(slot_release), .slot_release_id(slot_release_id));

	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	task automatic give_verdict();
		if (error_cnt == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : give_verdict

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic bus(input logic wr, input logic [6:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		r = avs_readdata;
		check(n < 50, 32'h1);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk_sys);
	endtask : bus

	task automatic wr(input logic [6:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask : wr

	task automatic rd_chk(input logic [6:0] a, input logic [31:0] exp);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		check(r, exp);
	endtask : rd_chk

	task automatic test_regs();
		rd_chk(group_walk_pkg::status_off, 32'h0);
		wr(7'h48, 32'h1234abcd);
		rd_chk(7'h48, 32'h0);
		wr(group_walk_pkg::disp_count_off, 32'h5555aaaa);
		rd_chk(group_walk_pkg::disp_count_off, 32'h0);
		wr(group_walk_pkg::x_init_off, 32'hdeadbeef);
		rd_chk(group_walk_pkg::x_init_off, 32'hdeadbeef);
	endtask : test_regs

	task automatic test_errors();
		logic [31:0] thr[3] = '{32'h00010121, 32'h00010221, 32'h00010100};
		logic [1:0] mode[3] = '{group_walk_pkg::simd32, group_walk_pkg::simd16,
			group_walk_pkg::simd8};
		for (int i = 0; i < 3; i++) begin
			wr(group_walk_pkg::thr_max_off, thr[i]);
			wr(group_walk_pkg::ctrl_off, {29'h0, mode[i], 1'b1});
			rd_chk(group_walk_pkg::status_off, 32'h4);
			check(disp_valid, 32'h0);
		end
	endtask : test_errors

	task automatic test_walk();
		logic [31:0] x;
		logic [31:0] y;
		logic [31:0] m;
		int n;
		x = 32'h1;
		y = 32'h0;
		wr(group_walk_pkg::x_init_off, 32'h1);
		wr(group_walk_pkg::x_max_off, 32'h2);
		wr(group_walk_pkg::y_init_off, 32'h0);
		wr(group_walk_pkg::y_max_off, 32'h1);
		wr(group_walk_pkg::z_init_off, 32'h0);
		wr(group_walk_pkg::z_max_off, 32'h0);
		wr(group_walk_pkg::thr_max_off, 32'h00010202);
		wr(group_walk_pkg::right_mask_off, 32'h0000ffff);
		wr(group_walk_pkg::bottom_mask_off, 32'h00ff00ff);
		wr(group_walk_pkg::scratch_off, 32'hfffff7ff);
		wr(group_walk_pkg::bind_off, 32'habcdef1f);
		wr(group_walk_pkg::sampler_off, 32'h1234567c);
		wr(group_walk_pkg::group_cfg_off, 32'h3000beef);
		wr(group_walk_pkg::pay_base_off, 32'h00010000);
		wr(group_walk_pkg::pay_len_off, 32'h00550203);
		wr(group_walk_pkg::ctrl_off, {29'h0, group_walk_pkg::simd16, 1'b1});
		rd_chk(group_walk_pkg::status_off, 32'h1);
		// Config writes while busy must not disturb the running walk.
		wr(group_walk_pkg::x_max_off, 32'h7);
		rd_chk(group_walk_pkg::x_max_off, 32'h2);
		hold <= 1'b0;
		for (int g = 0; g < 5; g++) begin
			slow <= (g < 2);
			for (int k = 0; k < 4; k++) begin
				n = 0;
				do begin
					@(posedge clk_sys);
					n++;
				end while (!(disp_valid === 1'b1 && disp_ready === 1'b1) && n < 100);
				m = (k == 3) ? 32'h000000ff : (k == 2) ? 32'h00ff00ff :
					(k == 1) ? 32'h0000ffff : 32'hffffffff;
				check(disp_exec_mask, m);
				check(disp_header[1], x);
				check(disp_header[6], y);
				check(disp_header[7], 32'h0);
				check(disp_header[5], 32'hfffff600 | n_disp);
				check(disp_header[4], 32'habcdef0b);
				check(disp_header[3], 32'h1234566b);
				check(disp_header[2], 32'h30000000 | (g << 24));
				check(disp_header[0], 32'h0000beef | (g << 24));
				check(disp_payload_addr, 32'h00010040 + k * 96);
				check({disp_mem_ctl, disp_payload_len}, 15'h5503);
				n_disp++;
			end
			if (x == 32'h2) begin
				x = 32'h0;
				y++;
			end else begin
				x++;
			end
		end
		n = 0;
		repeat (20) begin
			@(posedge clk_sys);
			n += (disp_valid === 1'b1);
		end
		check(n, 32'h0);
		rd_chk(group_walk_pkg::status_off, 32'h2);
	endtask : test_walk

	initial begin
		#2000000;
		error_cnt++;
		give_verdict();
	end

	initial begin
		resetn = 1'b0;
		avs_address = 7'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		hold = 1'b1;
		slow = 1'b0;
		error_cnt = 0;
		checked = 0;
		n_disp = 0;
		repeat (20) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		test_regs();
		test_errors();
		test_walk();
		give_verdict();
	end
endmodule : group_walk_dispatch_bench
